// ==== bench/dafc_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module dafc_capture (
  // clock and pacing
  input  wire logic            clock,
  input  wire logic            stall,
  // words from the converter
  input  wire logic            output_strobe,
  input  wire logic            powerdown_pin,
  input  wire logic [11:0]     channel_a_word,
  input  wire logic [11:0]     channel_b_word,
  input  wire logic            words_unsettled,
  // capture side
  output logic                 capture_ready = 1'b1,
  output logic                 got = 1'b0,
  output logic                 got_flag = 1'b0,
  output dafc_pkg::dafc_pair_t pair
);
  logic       prev = 1'b0;
  logic [3:0] cnt = 4'h0;
  // stalling lets the fifo fill: ready only one cycle in sixteen
  always @(posedge clock)
  begin
    prev <= output_strobe;
    got <= output_strobe && !prev && !powerdown_pin;
    pair <= {channel_a_word, channel_b_word};
    got_flag <= words_unsettled;
    cnt <= cnt + 4'h1;
    capture_ready <= !stall || cnt == 4'hf;
  end
endmodule
`default_nettype wire

// ==== bench/dafc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module dafc_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // controls
  input wire logic [1:0]  format_stabilizer_select,
  input wire logic        serial_enable,
  input wire logic        serial_twos_complement,
  input wire logic        powerdown_channel_a,
  input wire logic        powerdown_channel_b,
  // results
  input wire logic [11:0] channel_a_word,
  input wire logic [11:0] channel_b_word,
  input wire logic        output_strobe,
  input wire logic        powerdown_pin,
  input wire logic        duty_stabilizer,
  input wire logic        twos_complement
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  twos_pin_a:
    assert property ((!serial_enable && $stable(format_stabilizer_select))[*5]
      |-> twos_complement == format_stabilizer_select[1])
    else $error("format flag does not follow select pin");
  stab_pin_a:
    assert property ((!serial_enable && $stable(format_stabilizer_select))[*5]
      |-> duty_stabilizer == ^format_stabilizer_select)
    else $error("stabilizer flag does not follow select pin");
  serial_wins_a:
    assert property ((serial_enable && $stable(serial_twos_complement))[*5]
      |-> twos_complement == serial_twos_complement)
    else $error("serial setting did not override select pin");
  strobe_pulse_a:
    assert property (output_strobe |=> !output_strobe)
    else $error("strobe longer than one cycle");
  strobe_follow_a:
    assert property (!$past(reset) && ($changed(channel_a_word)
      || $changed(channel_b_word)) |=> output_strobe)
    else $error("word changed without strobe");
  word_hold_a:
    assert property (!$past(reset) && $changed(channel_a_word)
      |=> $stable(channel_a_word))
    else $error("word not held for its strobe");
  pd_merge_a:
    assert property (($stable(powerdown_channel_a)
      && $stable(powerdown_channel_b))[*4]
      |-> powerdown_pin == (powerdown_channel_a || powerdown_channel_b))
    else $error("power down output wrong");
  reset_clear_a:
    assert property (disable iff (1'b0) reset |=> !output_strobe
      && channel_a_word == 12'h000 && channel_b_word == 12'h000)
    else $error("outputs not cleared by reset");
endmodule
bind dafc_top dafc_props u_props (.clock(clock), .reset(reset),
  .format_stabilizer_select(format_stabilizer_select),
  .serial_enable(serial_enable),
  .serial_twos_complement(serial_twos_complement),
  .powerdown_channel_a(powerdown_channel_a),
  .powerdown_channel_b(powerdown_channel_b),
  .channel_a_word(channel_a_word), .channel_b_word(channel_b_word),
  .output_strobe(output_strobe), .powerdown_pin(powerdown_pin),
  .duty_stabilizer(duty_stabilizer), .twos_complement(twos_complement));
`default_nettype wire

// ==== bench/dafc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dafc_top_tb;
  logic        clock, reset, serial_enable, serial_twos, pd_a, pd_b;
  logic [1:0]  sel;
  logic        sample_valid, capture_ready, stall, got, strobe, pd_pin;
  logic [11:0] core_a, core_b, word_a, word_b;
  logic        stab, twos, sample_stall, cur_twos, exp_flag, seen_stall;
  logic        unsettled, got_flag;
  logic        uns_q [$];
  logic [31:0] seed = 32'h0000c7b4;
  logic [11:0] fs [5] = '{12'h000, 12'h400, 12'h800, 12'hc00, 12'hfff};
  int          err_total, comparisons, cycles;
  dafc_pkg::dafc_pair_t pair;
  dafc_pkg::dafc_pair_t exp_q [$];

  dafc_top dut (.clock(clock), .reset(reset),
    .format_stabilizer_select(sel), .serial_enable(serial_enable),
    .serial_twos_complement(serial_twos),
    .serial_duty_stabilizer(serial_twos), .powerdown_channel_a(pd_a),
    .powerdown_channel_b(pd_b), .sample_valid(sample_valid),
    .core_a_sample(core_a), .core_b_sample(core_b),
    .capture_ready(capture_ready), .channel_a_word(word_a),
    .channel_b_word(word_b), .output_strobe(strobe),
    .powerdown_pin(pd_pin), .words_unsettled(unsettled),
    .duty_stabilizer(stab), .twos_complement(twos),
    .sample_stall(sample_stall));
  dafc_capture cap (.clock(clock), .stall(stall), .output_strobe(strobe),
    .powerdown_pin(pd_pin), .channel_a_word(word_a),
    .channel_b_word(word_b), .capture_ready(capture_ready), .got(got),
    .words_unsettled(unsettled), .got_flag(got_flag), .pair(pair));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [11:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[11:0];
  endfunction

  function automatic logic [11:0] fmt(input logic [11:0] w);
    return cur_twos ? {~w[11], w[10:0]} : w;
  endfunction

  task automatic check(input logic [11:0] g, input logic [11:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic send(input logic [11:0] a, input logic [11:0] b);
    @(negedge clock);
    sample_valid = 1'b1;
    core_a = a;
    core_b = b;
    @(posedge clock);
    #1;
    if (!stall)
      check({11'h0, sample_stall}, 12'h000);
    // a pair met by a full fifo is refused and never comes out
    if (sample_stall !== 1'b1)
    begin
      exp_q.push_back({fmt(a), fmt(b)});
      uns_q.push_back(exp_flag);
    end
  endtask

  task automatic setup(input logic [1:0] c, input logic se, input logic st);
    @(negedge clock);
    sample_valid = 1'b0;
    sel = c;
    serial_enable = se;
    serial_twos = st;
    cur_twos = se ? st : c[1];
    repeat (8) @(negedge clock);
    check({11'h0, twos}, {11'h0, cur_twos});
    check({11'h0, stab}, {11'h0, se ? st : ^c});
  endtask

  task automatic drain();
    @(negedge clock);
    sample_valid = 1'b0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clock);
    check(12'(exp_q.size()), 12'h000);
  endtask

  always @(posedge clock)
    if (got)
    begin
      if (exp_q.size() == 0)
        check(12'h001, 12'h000);
      else
      begin
        check(pair.channel_a_word, exp_q[0].channel_a_word);
        check(pair.channel_b_word, exp_q[0].channel_b_word);
        check({11'h0, got_flag}, {11'h0, uns_q[0]});
        void'(exp_q.pop_front());
        void'(uns_q.pop_front());
      end
    end

  always @(posedge clock)
  begin
    cycles++;
    if (sample_stall === 1'b1)
      seen_stall = 1'b1;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    {serial_enable, serial_twos, pd_a, pd_b, sample_valid} = '0;
    {stall, exp_flag, seen_stall, cur_twos} = '0;
    {sel, core_a, core_b} = '0;
    reset = 1'b1;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    for (int c = 0; c < 6; c++)
    begin
      setup(2'(c * 3), c > 3, c == 4);
      foreach (fs[i]) send(fs[i], rnd());
      drain();
    end
    // a select change marks the pairs sampled while the setting settles
    setup(dafc_pkg::SEL_AGND, 1'b0, 1'b0);
    @(negedge clock);
    sel = dafc_pkg::SEL_THIRD;
    for (int j = 0; j < 8; j++)
    begin
      exp_flag = (j >= 1 && j <= dafc_pkg::SETTLE_CYC + 1);
      send(rnd(), rnd());
    end
    exp_flag = 1'b0;
    drain();
    stall = 1'b1;
    repeat (40) send(rnd(), rnd());
    check({11'h0, seen_stall}, 12'h001);
    stall = 1'b0;
    drain();
    for (int p = 1; p < 5; p++)
    begin
      {pd_b, pd_a} = 2'(p);
      repeat (6) @(negedge clock);
      check({11'h0, pd_pin}, {11'h0, p != 4});
    end
    summarize();
  end
endmodule
`default_nettype wire

// ==== design/dafc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dafc_fifo
#(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
      bump = '0;
    else
      bump = p + 1'b1;
  endfunction

  always_comb
  begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule
`default_nettype wire

// ==== design/dafc_pkg.sv ====
package dafc_pkg;

  // word width of one channel
  localparam int unsigned WORD_W = 12;
  localparam int unsigned MSB_POS = WORD_W - 1;
  // pipeline latency in clock cycles
  localparam int unsigned PIPE_LAT = 4;
  // fifo depth in pairs
  localparam int unsigned FIFO_DEPTH = 16;
  // cycles of unsettled-word flagging after a select change
  localparam int unsigned SETTLE_CYC = 4;
  // select level codes after quantisation of the four-level pin
  localparam logic [1:0] SEL_AGND = 2'h0;
  localparam logic [1:0] SEL_THIRD = 2'h1;
  localparam logic [1:0] SEL_TWO_THIRD = 2'h2;
  localparam logic [1:0] SEL_VA = 2'h3;
  // setting field positions
  localparam int unsigned SET_TWOS_POS = 1;
  localparam int unsigned SET_STAB_POS = 0;
  localparam logic [1:0] SET_RESET = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;

  typedef struct packed {
    logic twos_complement;
    logic duty_stabilizer;
  } dafc_setting_t;

  typedef struct packed {
    logic [WORD_W-1:0] channel_a_word;
    logic [WORD_W-1:0] channel_b_word;
  } dafc_pair_t;

  localparam int unsigned PAIR_W = 2 * WORD_W;

endpackage

// ==== design/dafc_top.sv ====
// What this block does
// - offset binary: raw code passes unchanged, zero at negative full scale
// - two's complement: offset binary code with its top bit inverted
// - select at supply level: two's complement, stabilizer off
// - select at ground: offset binary, stabilizer off
// - select at two thirds supply: two's complement, stabilizer on
// - select at one third supply: offset binary, stabilizer on
// - stabilizer on: accept 30 to 70 percent high time, steady clock
// - select change may spoil a few words; those are flagged invalid
// - serial control enabled: select pin is ignored entirely
// - two independent channels, each with its own 12-bit output word
// - one new word at most every second cycle, after the pipeline latency and any fifo wait
`timescale 1ns/1ps
`default_nettype none
module dafc_top
#(
  parameter int unsigned PIPE_LAT   = dafc_pkg::PIPE_LAT,
  parameter int unsigned FIFO_DEPTH = dafc_pkg::FIFO_DEPTH,
  parameter int unsigned SETTLE_CYC = dafc_pkg::SETTLE_CYC
)
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // quantised four-level select pin and serial override
  input  wire logic [1:0]                  format_stabilizer_select,
  input  wire logic                        serial_enable,
  input  wire logic                        serial_twos_complement,
  input  wire logic                        serial_duty_stabilizer,
  // power down pins
  input  wire logic                        powerdown_channel_a,
  input  wire logic                        powerdown_channel_b,
  // raw converter core samples, offset binary
  input  wire logic                        sample_valid,
  input  wire logic [dafc_pkg::WORD_W-1:0] core_a_sample,
  input  wire logic [dafc_pkg::WORD_W-1:0] core_b_sample,
  // parallel outputs toward capture logic
  input  wire logic                        capture_ready,
  output logic      [dafc_pkg::WORD_W-1:0] channel_a_word,
  output logic      [dafc_pkg::WORD_W-1:0] channel_b_word,
  output logic                             output_strobe,
  output logic                             powerdown_pin,
  output logic                             words_unsettled,
  // status
  output logic                             duty_stabilizer,
  output logic                             twos_complement,
  output logic                             sample_stall
);

  localparam int unsigned WW = dafc_pkg::WORD_W;
  localparam int unsigned PW = dafc_pkg::PAIR_W;
  localparam int unsigned SW = $clog2(SETTLE_CYC + 1);

  // two-stage synchronisers for pins
  logic [1:0] sel_s1;
  logic [1:0] sel_s2;
  logic [1:0] pd_s1;
  logic [1:0] pd_s2;
  logic [2:0] ser_s1;
  logic [2:0] ser_s2;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sel_s1 <= dafc_pkg::SEL_AGND;
      sel_s2 <= dafc_pkg::SEL_AGND;
      pd_s1  <= 2'h0;
      pd_s2  <= 2'h0;
      ser_s1 <= 3'h0;
      ser_s2 <= 3'h0;
    end
    else
    begin
      sel_s1 <= format_stabilizer_select;
      sel_s2 <= sel_s1;
      pd_s1  <= {powerdown_channel_b, powerdown_channel_a};
      pd_s2  <= pd_s1;
      ser_s1 <= {serial_enable, serial_twos_complement,
                 serial_duty_stabilizer};
      ser_s2 <= ser_s1;
    end
  end

  // decode of the four select levels
  function automatic dafc_pkg::dafc_setting_t decode_sel(
    input logic [1:0] sel
  );
    dafc_pkg::dafc_setting_t s;
    s = '0;
    case (sel)
      dafc_pkg::SEL_VA:        s = '{1'b1, 1'b0};
      dafc_pkg::SEL_AGND:      s = '{1'b0, 1'b0};
      dafc_pkg::SEL_TWO_THIRD: s = '{1'b1, 1'b1};
      dafc_pkg::SEL_THIRD:     s = '{1'b0, 1'b1};
      default:                 s = '{1'b0, 1'b0};
    endcase
    decode_sel = s;
  endfunction

  // format conversion: invert the top bit for two's complement
  function automatic logic [WW-1:0] fmt(
    input logic [WW-1:0] raw,
    input logic          twos
  );
    fmt = raw;
    if (twos)
      fmt[dafc_pkg::MSB_POS] = ~raw[dafc_pkg::MSB_POS];
  endfunction

  dafc_pkg::dafc_setting_t setting;
  dafc_pkg::dafc_setting_t next_setting;
  logic [SW-1:0]           settle;
  logic [SW-1:0]           next_settle;

  always_comb
  begin
    if (ser_s2[2])
    begin
      next_setting.twos_complement = ser_s2[dafc_pkg::SET_TWOS_POS];
      next_setting.duty_stabilizer = ser_s2[dafc_pkg::SET_STAB_POS];
    end
    else
      next_setting = decode_sel(sel_s2);
    // settle restarts on every change, so back-to-back changes extend it
    next_settle = settle;
    if (next_setting != setting)
      next_settle = SW'(SETTLE_CYC);
    else if (settle != '0)
      next_settle = settle - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      setting <= dafc_pkg::SET_RESET;
      settle  <= '0;
    end
    else
    begin
      setting <= next_setting;
      settle  <= next_settle;
    end
  end

  // PIPE_LAT-stage pipeline, one pair per cycle, frozen while the fifo is full
  dafc_pkg::dafc_pair_t pipe [PIPE_LAT];
  logic [PIPE_LAT-1:0]  pipe_v;
  logic [PIPE_LAT-1:0]  pipe_u;
  dafc_pkg::dafc_pair_t next_pipe0;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  dafc_pkg::dafc_pair_t fifo_out;
  logic [PW-1:0]        fifo_out_bits;
  logic                 fifo_unsettled;
  logic [PIPE_LAT-1:0]  unsettled_mark;
  dafc_pkg::dafc_pair_t next_pipe [PIPE_LAT];
  logic [PIPE_LAT-1:0]  next_pipe_v;
  logic [PIPE_LAT-1:0]  next_pipe_u;

  always_comb
  begin
    // each channel formatted on its own bus
    next_pipe0.channel_a_word = fmt(core_a_sample, setting.twos_complement);
    next_pipe0.channel_b_word = fmt(core_b_sample, setting.twos_complement);
  end

  // pipeline advances only when the fifo can take its output
  // a pair met by a full fifo is dropped, not held back
  always_comb
  begin
    next_pipe   = pipe;
    next_pipe_v = pipe_v;
    next_pipe_u = pipe_u;
    if (fifo_in_ready)
    begin
      next_pipe[0]   = next_pipe0;
      next_pipe_v[0] = sample_valid;
      next_pipe_u[0] = (settle != '0) || (next_setting != setting);
      for (int i = 1; i < PIPE_LAT; i++)
      begin
        next_pipe[i]   = pipe[i-1];
        next_pipe_v[i] = pipe_v[i-1];
        next_pipe_u[i] = pipe_u[i-1];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pipe_v <= '0;
      pipe_u <= '0;
      for (int i = 0; i < PIPE_LAT; i++)
        pipe[i] <= '0;
    end
    else
    begin
      pipe   <= next_pipe;
      pipe_v <= next_pipe_v;
      pipe_u <= next_pipe_u;
    end
  end

  assign unsettled_mark = pipe_u;

  // unsettled flag travels in the fifo next to the pair
  logic [PW:0] fifo_in_bits;
  logic [PW:0] fifo_out_all;

  assign fifo_in_bits   = {unsettled_mark[PIPE_LAT-1], pipe[PIPE_LAT-1]};
  assign fifo_out_bits  = fifo_out_all[PW-1:0];
  assign fifo_unsettled = fifo_out_all[PW];
  assign fifo_out       = fifo_out_bits;

  logic strobe_phase;
  logic next_strobe_phase;
  logic take;

  dafc_fifo
  #(
    .WIDTH (PW + 1),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (pipe_v[PIPE_LAT-1]),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_bits),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_all)
  );

  // present a word, then raise the strobe the next cycle for capture
  logic [WW-1:0] next_a;
  logic [WW-1:0] next_b;
  logic          next_unsettled;
  logic          next_pd;
  logic          next_strobe;
  logic          next_stab;
  logic          next_twos;
  logic          next_stall;

  always_comb
  begin
    // no take while the strobe of the last word is still pending
    take              = fifo_out_valid && capture_ready && !strobe_phase;
    next_strobe_phase = take;
    next_a            = channel_a_word;
    next_b            = channel_b_word;
    next_unsettled    = words_unsettled;
    if (take)
    begin
      next_a         = fifo_out.channel_a_word;
      next_b         = fifo_out.channel_b_word;
      next_unsettled = fifo_unsettled;
    end
    next_pd = pd_s2[0] || pd_s2[1];
    // strobe trails the word by one cycle, so the word is steady at its rise
    next_strobe = strobe_phase;
    next_stab   = setting.duty_stabilizer;
    next_twos   = setting.twos_complement;
    // stall reports a refusal in the cycle after the pipeline freezes
    next_stall  = !fifo_in_ready;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      strobe_phase    <= 1'b0;
      channel_a_word  <= dafc_pkg::WORD_RESET;
      channel_b_word  <= dafc_pkg::WORD_RESET;
      words_unsettled <= 1'b0;
      output_strobe   <= 1'b0;
      powerdown_pin   <= 1'b0;
      duty_stabilizer <= 1'b0;
      twos_complement <= 1'b0;
      sample_stall    <= 1'b0;
    end
    else
    begin
      strobe_phase    <= next_strobe_phase;
      channel_a_word  <= next_a;
      channel_b_word  <= next_b;
      words_unsettled <= next_unsettled;
      output_strobe   <= next_strobe;
      powerdown_pin   <= next_pd;
      duty_stabilizer <= next_stab;
      twos_complement <= next_twos;
      sample_stall    <= next_stall;
    end
  end

endmodule
`default_nettype wire
